// file: tpc_pkg.sv
`default_nettype none
package tpc_pkg;
  // byte register offsets (one aligned word each)
  localparam logic [7:0] OFS_TSC = 8'h00;   // timer_status_control
  localparam logic [7:0] OFS_CNT_H = 8'h04;
  localparam logic [7:0] OFS_CNT_L = 8'h08;
  localparam logic [7:0] OFS_MOD_H = 8'h0C;
  localparam logic [7:0] OFS_MOD_L = 8'h10;
  localparam logic [7:0] OFS_CSC = 8'h14;   // channel_status_control
  localparam logic [7:0] OFS_CV_H = 8'h18;  // channel_value_high
  localparam logic [7:0] OFS_CV_L = 8'h1C;  // channel_value_low
  // timer_status_control fields
  localparam int TSC_TOF = 7;
  localparam int TSC_OVERFLOW_INTERRUPT_ENABLE = 6;
  localparam int TSC_CENTER_ALIGNED_SELECT = 5;
  localparam int TSC_CLKS_LO = 3;
  localparam int TSC_PS_LO = 0;
  // channel_status_control fields
  localparam int CSC_MS_LO = 4;
  localparam int CSC_ELS_LO = 2;
  localparam logic [7:0] TSC_RESET = 8'h00;
  localparam logic [7:0] CSC_RESET = 8'h00;
  localparam logic [15:0] CV_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] MOD_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_MAX_M1 = 16'hFFFE;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    CLK_NONE = 2'b00,
    CLK_BUS = 2'b01,
    CLK_FIXED = 2'b10,
    CLK_EXT = 2'b11
  } tpc_clks_t;
  typedef enum logic [2:0] {
    CM_OFF = 3'b000,
    CM_CAPTURE = 3'b001,
    CM_COMPARE = 3'b010,
    CM_EDGE_PWM = 3'b011,
    CM_CENTER_PWM = 3'b100
  } tpc_cmode_t;
  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] dat;
    logic we;
    logic sel;
  } tpc_req_t;
endpackage : tpc_pkg
`default_nettype wire

// file: tpc_timer.sv
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`default_nettype none
// Behaviour
// - reset clears both channel value bytes
// - capture read latches other byte coherently
// - channel status/control write unlatches coherency latch
// - capture mode ignores channel value writes
// - debug halt freezes read latch state against reads
// - halt reads return live channel value
// - compare/PWM writes buffer until both bytes
// - clock off: transfer on second byte
// - compare: transfer at next counter change
// - PWM: transfer on step to modulus
// - halt writes go straight to register
// - halt writes keep partial sequence intact
// - one 16-bit counter, prescaler, modulus
// - center select: up/down, channel PWM unless ELS bits are 00
// - clock select 00 off,01 bus,10 fixed,11 ext
// - clock select resets to zero
// - disabling clock keeps counter and registers
// - fixed clock synchronised only when loop engaged
// - interrupt while flag and enable set
// - up count overflow at wrap or modulus
// - center mode overflow at turn from modulus
// - channel mode decoded from select bits
module tpc_timer (
  input wire logic clk, // 50 MHz bus clock
  input wire logic resetn, // async active-low reset
  input wire logic clk_en, // freezes all state when low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects, lane 0 used
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic debug_halt, // debug halt active
  input wire logic loop_engaged, // clock loop engaged at chip level
  input wire logic fixed_clk_tick, // fixed system clock level
  input wire logic ext_clk_pin, // external clock from channel pin
  input wire logic capture_event, // channel capture edge event
  output logic overflow_irq, // static overflow request
  output logic [15:0] channel_value, // active channel register
  output logic [2:0] channel_mode // decoded mode
);
  ////////////////////////////////////////////////////////////////////
  tpc_pkg::tpc_req_t req;
  logic [7:0] tsc_r;
  logic [7:0] csc_r;
  logic [15:0] cnt_r;
  logic [15:0] mod_r;
  logic [15:0] cv_r;
  logic [15:0] wbuf_r;
  logic [1:0] wseen_r;
  logic wpend_r;
  logic [7:0] rbuf_r;
  logic rlatch_r;
  logic rlatch_hi_r;
  logic up_r;
  logic [6:0] pre_r;
  logic [1:0] fix_sync_r;
  logic fix_prev_r;
  logic [1:0] ext_sync_r;
  logic ext_prev_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic access, wr, rd;
  logic src_tick, cnt_step, pre_done;
  logic [15:0] top;
  logic [15:0] cnt_nxt;
  logic center_aligned_select;
  tpc_pkg::tpc_clks_t clks;
  tpc_pkg::tpc_cmode_t mode;
  logic capture_m;

  assign req = '{adr: wb_adr_i, dat: wb_dat_i[7:0], we: wb_we_i, sel: wb_sel_i[0]};
  assign access = wb_cyc_i & wb_stb_i & ~ack_r & clk_en;
  assign wr = access & req.we & req.sel;
  assign rd = access & ~req.we;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign center_aligned_select = tsc_r[tpc_pkg::TSC_CENTER_ALIGNED_SELECT];
  assign clks = tpc_pkg::tpc_clks_t'(tsc_r[tpc_pkg::TSC_CLKS_LO +: 2]);
  assign overflow_irq = tsc_r[tpc_pkg::TSC_TOF] & tsc_r[tpc_pkg::TSC_OVERFLOW_INTERRUPT_ENABLE];
  assign channel_value = cv_r;
  assign channel_mode = mode;
  assign capture_m = (mode == tpc_pkg::CM_CAPTURE);

  ////////////////////////////////////////////////////////////////////
  // channel mode decode
  always_comb begin
    if (csc_r[tpc_pkg::CSC_ELS_LO +: 2] == 2'b00) begin
      mode = tpc_pkg::CM_OFF;
    end else if (center_aligned_select) begin
      mode = tpc_pkg::CM_CENTER_PWM;
    end else begin
      case (csc_r[tpc_pkg::CSC_MS_LO +: 2])
        2'b00: mode = tpc_pkg::CM_CAPTURE;
        2'b01: mode = tpc_pkg::CM_COMPARE;
        default: mode = tpc_pkg::CM_EDGE_PWM;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock source and prescaler
  always_comb begin
    case (clks)
      tpc_pkg::CLK_BUS: src_tick = 1'b1;
      // without an engaged loop the fixed clock is the bus clock
      tpc_pkg::CLK_FIXED: src_tick = loop_engaged ? (fix_sync_r[1] & ~fix_prev_r) : 1'b1;
      // rising edge of the synchronised pin; only valid up to bus/4
      tpc_pkg::CLK_EXT: src_tick = ext_sync_r[1] & ~ext_prev_r;
      default: src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fix_sync_r <= 2'b00;
      fix_prev_r <= 1'b0;
      ext_sync_r <= 2'b00;
      ext_prev_r <= 1'b0;
    end else if (clk_en) begin
      fix_sync_r <= {fix_sync_r[0], fixed_clk_tick};
      fix_prev_r <= fix_sync_r[1];
      ext_sync_r <= {ext_sync_r[0], ext_clk_pin};
      ext_prev_r <= ext_sync_r[1];
    end
  end

  // prescale factor 2^ps, ps in bits 2:0
  assign pre_done = (pre_r == ((7'd1 << tsc_r[tpc_pkg::TSC_PS_LO +: 3]) - 7'd1));
  assign cnt_step = src_tick & pre_done;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_r <= 7'd0;
    end else if (clk_en && src_tick) begin
      pre_r <= pre_done ? 7'd0 : pre_r + 7'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // main counter
  assign top = (mod_r == tpc_pkg::MOD_RESET) ? tpc_pkg::CNT_MAX : mod_r;

  always_comb begin
    if (center_aligned_select) begin
      if (up_r) begin
        cnt_nxt = (cnt_r >= top) ? cnt_r - 16'd1 : cnt_r + 16'd1;
      end else begin
        cnt_nxt = (cnt_r == 16'd0) ? cnt_r + 16'd1 : cnt_r - 16'd1;
      end
    end else begin
      cnt_nxt = (cnt_r >= top) ? 16'd0 : cnt_r + 16'd1;
    end
  end

  // clock select 00 stops stepping only; values are kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= tpc_pkg::CNT_RESET;
      up_r <= 1'b1;
    end else if (clk_en) begin
      if (wr && (req.adr == tpc_pkg::OFS_CNT_H || req.adr == tpc_pkg::OFS_CNT_L)) begin
        cnt_r <= tpc_pkg::CNT_RESET;
        up_r <= 1'b1;
      end else if (cnt_step && !debug_halt) begin
        cnt_r <= cnt_nxt;
        if (center_aligned_select) begin
          up_r <= (up_r && cnt_r >= top) ? 1'b0 : (!up_r && cnt_r == 16'd0) ? 1'b1 : up_r;
        end else begin
          up_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timer status/control, modulus, channel status/control
  logic tof_set;
  assign tof_set = cnt_step & ~debug_halt & (center_aligned_select ? (up_r & (cnt_r >= top))
                                                   : (cnt_r >= top));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tsc_r <= tpc_pkg::TSC_RESET;
    end else if (clk_en) begin
      if (wr && req.adr == tpc_pkg::OFS_TSC) begin
        tsc_r[6:0] <= req.dat[6:0];
      end
      // flag clears by writing 0; a simultaneous overflow wins
      if (tof_set) begin
        tsc_r[tpc_pkg::TSC_TOF] <= 1'b1;
      end else if (wr && req.adr == tpc_pkg::OFS_TSC && !req.dat[tpc_pkg::TSC_TOF]) begin
        tsc_r[tpc_pkg::TSC_TOF] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mod_r <= tpc_pkg::MOD_RESET;
      csc_r <= tpc_pkg::CSC_RESET;
    end else if (clk_en && wr) begin
      if (req.adr == tpc_pkg::OFS_MOD_H) mod_r[15:8] <= req.dat;
      if (req.adr == tpc_pkg::OFS_MOD_L) mod_r[7:0] <= req.dat;
      if (req.adr == tpc_pkg::OFS_CSC) csc_r <= req.dat;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // channel value write path
  logic wr_cvh, wr_cvl, csc_wr, seq_done, pwm_point, do_xfer;
  assign wr_cvh = wr & (req.adr == tpc_pkg::OFS_CV_H) & ~capture_m;
  assign wr_cvl = wr & (req.adr == tpc_pkg::OFS_CV_L) & ~capture_m;
  assign csc_wr = wr & (req.adr == tpc_pkg::OFS_CSC);
  assign seq_done = ~debug_halt & ((wr_cvh & wseen_r[0]) | (wr_cvl & wseen_r[1]));
  assign pwm_point = cnt_step & ~debug_halt & up_r & (cnt_nxt == top) & (cnt_r != top);

  always_comb begin
    if (clks == tpc_pkg::CLK_NONE) begin
      do_xfer = wpend_r;
    end else if (mode == tpc_pkg::CM_COMPARE || mode == tpc_pkg::CM_OFF) begin
      do_xfer = wpend_r & cnt_step & ~debug_halt;
    end else begin
      do_xfer = wpend_r & pwm_point;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wbuf_r <= tpc_pkg::CV_RESET;
      wseen_r <= 2'b00;
      wpend_r <= 1'b0;
    end else if (clk_en) begin
      if (csc_wr) begin
        wseen_r <= 2'b00;
      end else if (!debug_halt) begin
        if (seq_done) begin
          wseen_r <= 2'b00;
        end else begin
          if (wr_cvh) wseen_r[1] <= 1'b1;
          if (wr_cvl) wseen_r[0] <= 1'b1;
        end
        if (wr_cvh) wbuf_r[15:8] <= req.dat;
        if (wr_cvl) wbuf_r[7:0] <= req.dat;
      end
      if (seq_done) begin
        wpend_r <= 1'b1;
      end else if (do_xfer) begin
        wpend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cv_r <= tpc_pkg::CV_RESET;
    end else if (clk_en) begin
      if (capture_m && capture_event) begin
        cv_r <= cnt_r;
      end else if (debug_halt && wr_cvh) begin
        cv_r[15:8] <= req.dat;
      end else if (debug_halt && wr_cvl) begin
        cv_r[7:0] <= req.dat;
      end else if (do_xfer) begin
        cv_r <= wbuf_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // channel value read coherency
  logic rd_cvh, rd_cvl;
  assign rd_cvh = rd & (req.adr == tpc_pkg::OFS_CV_H) & capture_m & ~debug_halt;
  assign rd_cvl = rd & (req.adr == tpc_pkg::OFS_CV_L) & capture_m & ~debug_halt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rlatch_r <= 1'b0;
      rlatch_hi_r <= 1'b0;
      rbuf_r <= 8'h00;
    end else if (clk_en) begin
      if (csc_wr) begin
        rlatch_r <= 1'b0;
      end else if (rd_cvh || rd_cvl) begin // frozen in halt
        if (rlatch_r) begin
          // only the opposite half releases the latch; rereading the first half keeps it
          if (rd_cvh != rlatch_hi_r) rlatch_r <= 1'b0;
        end else begin
          rlatch_r <= 1'b1;
          rlatch_hi_r <= rd_cvh;
          rbuf_r <= rd_cvh ? cv_r[7:0] : cv_r[15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wishbone read mux and ack
  logic [7:0] rdata;
  always_comb begin
    case (req.adr)
      tpc_pkg::OFS_TSC: rdata = tsc_r;
      tpc_pkg::OFS_CNT_H: rdata = cnt_r[15:8];
      tpc_pkg::OFS_CNT_L: rdata = cnt_r[7:0];
      tpc_pkg::OFS_MOD_H: rdata = mod_r[15:8];
      tpc_pkg::OFS_MOD_L: rdata = mod_r[7:0];
      tpc_pkg::OFS_CSC: rdata = csc_r;
      // the buffered half is served only outside halt
      tpc_pkg::OFS_CV_H: rdata = (rlatch_r && !rlatch_hi_r && !debug_halt && capture_m) ? rbuf_r : cv_r[15:8];
      tpc_pkg::OFS_CV_L: rdata = (rlatch_r && rlatch_hi_r && !debug_halt && capture_m) ? rbuf_r : cv_r[7:0];
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_r <= access;
      if (rd) dat_r <= {24'h00_0000, rdata};
    end
  end
endmodule : tpc_timer
`default_nettype wire

// file: tpc_timer_properties.sv
`default_nettype none
module tpc_timer_properties (
  input wire logic clk, // bus clock
  input wire logic resetn, // reset
  input wire logic clk_en, // run
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // wdata
  input wire logic [31:0] wb_dat_o, // rdata
  input wire logic wb_ack_o, // ack
  input wire logic debug_halt, // halt
  input wire logic capture_event, // capture
  input wire logic [15:0] channel_value, // value
  input wire logic [2:0] channel_mode // mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic tk, tkw, cvw;
  logic [7:0] cv_lo, dl;
  assign tk = wb_cyc_i & wb_stb_i & clk_en & !wb_ack_o;
  assign tkw = tk & wb_we_i & wb_sel_i[0];
  assign cvw = tkw & (wb_adr_i == tpc_pkg::OFS_CV_H || wb_adr_i == tpc_pkg::OFS_CV_L);
  assign cv_lo = channel_value[7:0];
  assign dl = wb_dat_i[7:0];
  ////////////////////////////////////////////////////////////////
  property p_ack; tk |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_drop; wb_ack_o && clk_en |=> !wb_ack_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
  property p_rst; $rose(resetn) |-> channel_value == 16'h0000 && channel_mode == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("value not cleared by reset");
  property p_cap_ro;
    channel_mode == tpc_pkg::CM_CAPTURE && cvw && !capture_event |=> $stable(channel_value);
  endproperty
  a_cap_ro: assert property (p_cap_ro) else $error("capture value written");
  property p_halt_rd;
    debug_halt && tk && !wb_we_i && wb_adr_i == tpc_pkg::OFS_CV_L |=> wb_dat_o[7:0] == $past(cv_lo);
  endproperty
  a_halt_rd: assert property (p_halt_rd) else $error("halt read not live");
  property p_halt_wr;
    debug_halt && cvw && wb_adr_i == tpc_pkg::OFS_CV_L
      && channel_mode inside {tpc_pkg::CM_COMPARE, tpc_pkg::CM_EDGE_PWM} |=> cv_lo == $past(dl);
  endproperty
  a_halt_wr: assert property (p_halt_wr) else $error("halt write not direct");
  property p_halt_wr_hi;
    debug_halt && cvw && wb_adr_i == tpc_pkg::OFS_CV_H
      && channel_mode inside {tpc_pkg::CM_COMPARE, tpc_pkg::CM_EDGE_PWM} |=> channel_value[15:8] == $past(dl);
  endproperty
  a_halt_wr_hi: assert property (p_halt_wr_hi) else $error("halt high write not direct");
  property p_mode;
    !(tkw && (wb_adr_i == tpc_pkg::OFS_CSC || wb_adr_i == tpc_pkg::OFS_TSC)) |=> $stable(channel_mode);
  endproperty
  a_mode: assert property (p_mode) else $error("mode changed without write");
  property p_freeze; !clk_en |=> $stable(channel_value) && $stable(wb_ack_o); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  c_cap: cover property (channel_mode == tpc_pkg::CM_CAPTURE && capture_event);
  c_halt_wr: cover property (debug_halt && cvw);
  c_halt_rd: cover property (debug_halt && tk && !wb_we_i);
endmodule // tpc_timer_properties
`default_nettype wire

// file: tpc_cpu_model.sv
`default_nettype none
module tpc_cpu_model (
  input wire logic clk, // bus clock
  output logic cyc, // cycle
  output logic stb, // strobe
  output logic we, // write
  output logic [7:0] adr, // address
  output logic [3:0] sel, // lanes
  output logic [31:0] dat, // wdata
  input wire logic ack, // ack
  input wire logic [31:0] rdat // rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
  end
  // idle lines are scrambled so a slave that samples late sees junk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= ~a;
    dat <= ~dat;
  endtask
endmodule // tpc_cpu_model
`default_nettype wire

// file: tb_timer_channel_value_and_counter.sv
`default_nettype none
module tb_timer_channel_value_and_counter;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, clk_en, debug_halt, cap, cyc, stb, we, ack, irq, loop_on, slow;
  logic [7:0] adr, q;
  logic [3:0] sel;
  logic [31:0] wd, rdat;
  logic [15:0] cv, e, f;
  logic [2:0] mode;
  int err_total, check_count, ncyc, i;
  logic [7:0] cs [6] = '{8'h00, 8'h04, 8'h0C, 8'h14, 8'h10, 8'h28};
  logic [2:0] md [6] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h0, 3'h3};
  tpc_cpu_model cpu (.clk, .cyc, .stb, .we, .adr, .sel, .dat(wd), .ack, .rdat);
  tpc_timer dut (.clk, .resetn, .clk_en, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .debug_halt, .loop_engaged(loop_on),
    .fixed_clk_tick(slow), .ext_clk_pin(slow), .capture_event(cap), .overflow_irq(irq),
    .channel_value(cv), .channel_mode(mode));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    cpu.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("read %h", a), {8'h00, q}, {8'h00, x});
  endtask
  task automatic wcv(input logic [15:0] x, input int n);
    for (int k = 0; k < n && cv !== x; k++) @(posedge clk);
    chk("channel_value", cv, x);
  endtask
  task automatic pulse;
    @(posedge clk);
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
    @(posedge clk);
  endtask
  task automatic print_verdict;
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {resetn, debug_halt, cap, loop_on, slow} = '0;
    clk_en = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rc(tpc_pkg::OFS_CV_H, 8'h00);
    rc(tpc_pkg::OFS_CV_L, 8'h00);
    rc(tpc_pkg::OFS_TSC, 8'h00);
    rc(8'h20, 8'h00);
    for (i = 0; i < 6; i++) begin
      wr(tpc_pkg::OFS_CSC, cs[i]);
      chk("mode", {13'h0, mode}, {13'h0, md[i]});
    end
    wr(tpc_pkg::OFS_TSC, 8'h20);
    wr(tpc_pkg::OFS_CSC, 8'h08);
    chk("mode", {13'h0, mode}, 16'h0004);
    // compare mode, clock off: second byte lands at once
    wr(tpc_pkg::OFS_TSC, 8'h00);
    wr(tpc_pkg::OFS_CSC, 8'h14);
    wr(tpc_pkg::OFS_CV_H, 8'h12);
    repeat (2) @(posedge clk);
    chk("channel_value", cv, 16'h0000);
    wr(tpc_pkg::OFS_CV_L, 8'h34);
    wcv(16'h1234, 2);
    wr(tpc_pkg::OFS_CV_L, 8'h56);
    debug_halt <= 1'b1;
    wr(tpc_pkg::OFS_CV_H, 8'hAB);
    wcv(16'hAB34, 2);
    wr(tpc_pkg::OFS_CV_L, 8'hCD);
    wcv(16'hABCD, 2);
    debug_halt <= 1'b0;
    wr(tpc_pkg::OFS_CV_H, 8'h78);
    wcv(16'h7856, 2);
    // bus clock running: half a pair must stay buffered
    wr(tpc_pkg::OFS_TSC, 8'h08);
    wr(tpc_pkg::OFS_CV_H, 8'h11);
    repeat (8) @(posedge clk);
    chk("channel_value", cv, 16'h7856);
    wr(tpc_pkg::OFS_CV_L, 8'h22);
    wcv(16'h1122, 3);
    wr(tpc_pkg::OFS_MOD_L, 8'h10);
    wr(tpc_pkg::OFS_CNT_L, 8'h00);
    wr(tpc_pkg::OFS_CSC, 8'h28);
    wr(tpc_pkg::OFS_CV_H, 8'h00);
    wr(tpc_pkg::OFS_CV_L, 8'h07);
    wcv(16'h0007, 40);
    wr(tpc_pkg::OFS_TSC, 8'h48);
    for (i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
    chk("overflow_irq", {15'h0, irq}, 16'h0001);
    wr(tpc_pkg::OFS_TSC, 8'h80);
    chk("overflow_irq", {15'h0, irq}, 16'h0000);
    rc(tpc_pkg::OFS_TSC, 8'h80);
    cpu.xfer(1'b0, tpc_pkg::OFS_CNT_L, 8'h00, q);
    e = {8'h00, q};
    repeat (20) @(posedge clk);
    rc(tpc_pkg::OFS_CNT_L, e[7:0]);
    // capture: free-running count so every capture differs
    wr(tpc_pkg::OFS_MOD_L, 8'h00);
    wr(tpc_pkg::OFS_TSC, 8'h08);
    wr(tpc_pkg::OFS_CSC, 8'h04);
    pulse();
    e = cv;
    rc(tpc_pkg::OFS_CV_H, e[15:8]);
    pulse();
    f = cv;
    wr(tpc_pkg::OFS_CV_L, 8'h5A);
    chk("channel_value", cv, f);
    rc(tpc_pkg::OFS_CV_L, e[7:0]);
    rc(tpc_pkg::OFS_CV_H, cv[15:8]);
    pulse();
    wr(tpc_pkg::OFS_CSC, 8'h04);
    rc(tpc_pkg::OFS_CV_L, cv[7:0]);
    e = cv;
    rc(tpc_pkg::OFS_CV_H, e[15:8]);
    rc(tpc_pkg::OFS_CV_H, e[15:8]);
    rc(tpc_pkg::OFS_CV_H, e[15:8]);
    debug_halt <= 1'b1;
    pulse();
    rc(tpc_pkg::OFS_CV_L, cv[7:0]);
    rc(tpc_pkg::OFS_CV_H, cv[15:8]);
    debug_halt <= 1'b0;
    rc(tpc_pkg::OFS_CV_L, e[7:0]);
    // synchronised sources: three pin rising edges at bus/4 give three counts
    loop_on <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(tpc_pkg::OFS_TSC, k ? 8'h10 : 8'h18);
      wr(tpc_pkg::OFS_CNT_L, 8'h00);
      for (i = 0; i < 6; i++) begin
        repeat (2) @(posedge clk);
        slow <= ~slow;
      end
      repeat (4) @(posedge clk);
      rc(tpc_pkg::OFS_CNT_L, 8'h03);
    end
    // a capture edge while frozen must be lost
    f = cv;
    clk_en <= 1'b0;
    pulse();
    chk("channel_value", cv, f);
    clk_en <= 1'b1;
    print_verdict();
  end
endmodule // tb_timer_channel_value_and_counter
bind tpc_timer tpc_timer_properties u_props (.clk, .resetn, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .debug_halt, .capture_event, .channel_value,
  .channel_mode);
`default_nettype wire
